// [rtl/srtc_seconds_clock.v]
// Seconds counter real-time clock with alarm, periodic event and Wishbone slave.
`include "srtc_defs.vh"

module srtc_seconds_clock #(
    parameter SECOND_CYCLES = `SRTC_SECOND_CYCLES
) (
    input wire clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [31:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    output reg irq_o
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function [15:0] merge16;
        input [15:0] old_val;
        input [31:0] new_val;
        input [3:0] sel;
        begin
            merge16[7:0] = sel[0] ? new_val[7:0] : old_val[7:0];
            merge16[15:8] = sel[1] ? new_val[15:8] : old_val[15:8];
        end
    endfunction

    function [15:0] lfsr_step;
        input [15:0] v;
        begin
            lfsr_step = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
        end
    endfunction

    function is_index;
        input [29:0] a;
        input [15:0] i;
        begin
            is_index = (a == {14'h0000, i});
        end
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    reg [31:0] seconds_reg;
    reg [31:0] alarm_time_reg;
    reg alarm_enable_bit_reg;
    reg [2:0] periodic_interval_select_reg;
    reg valid_reg;
    reg [2:0] busy_cnt_reg;
    reg [15:0] time_write_tracker_reg;
    reg [15:0] lfsr_reg;
    reg [31:0] tick_cnt_reg;
    reg [5:0] period_cnt_reg;
    reg [1:0] irq_status_reg;
    reg [1:0] irq_mask_reg;
    reg [31:0] rd_next;
    reg hit_next;
    reg tick_pulse;
    reg periodic_pulse;
    reg alarm_pulse;
    reg [5:0] period_last;
    reg [31:0] seconds_next;
    reg [1:0] status_next;
    reg [1:0] mask_next;

    wire [29:0] idx = wb_adr_i[31:2];
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire wr = req && wb_we_i && hit_next;
    // Write strobes, one for each writable register.
    wire wr_sec_hi = wr && is_index(idx, `SRTC_IDX_SEC_UPPER);
    wire wr_sec_lo = wr && is_index(idx, `SRTC_IDX_SEC_LOWER);
    wire wr_alm_hi = wr && is_index(idx, `SRTC_IDX_ALM_UPPER);
    wire wr_alm_lo = wr && is_index(idx, `SRTC_IDX_ALM_LOWER);
    wire wr_ctrl = wr && is_index(idx, `SRTC_IDX_CTRL);
    wire wr_status = wr && is_index(idx, `SRTC_IDX_IRQ_STATUS);
    wire wr_mask = wr && is_index(idx, `SRTC_IDX_IRQ_MASK);
    wire wr_time = wr_sec_hi || wr_sec_lo;
    wire busy = (busy_cnt_reg != 3'h0);

    // ****************************************************************
    // Address decode and read data
    // ****************************************************************
    always @*
    begin
        hit_next = 1'b1;
        rd_next = 32'h0000_0000;
        case (idx)
            {14'h0000, `SRTC_IDX_WR_TRACKER}: rd_next[15:0] = time_write_tracker_reg;
            {14'h0000, `SRTC_IDX_SEC_UPPER}: rd_next[15:0] = seconds_reg[31:16];
            {14'h0000, `SRTC_IDX_SEC_LOWER}: rd_next[15:0] = seconds_reg[15:0];
            {14'h0000, `SRTC_IDX_ALM_UPPER}: rd_next[15:0] = alarm_time_reg[31:16];
            {14'h0000, `SRTC_IDX_ALM_LOWER}: rd_next[15:0] = alarm_time_reg[15:0];
            {14'h0000, `SRTC_IDX_CTRL}:
            begin
                rd_next[`SRTC_CTRL_VALID_BIT] = valid_reg;
                rd_next[`SRTC_CTRL_BUSY_BIT] = busy;
                rd_next[`SRTC_CTRL_ALM_EN_BIT] = alarm_enable_bit_reg;
                rd_next[`SRTC_CTRL_PINT_HI:`SRTC_CTRL_PINT_LO] = periodic_interval_select_reg;
            end
            {14'h0000, `SRTC_IDX_IRQ_STATUS}: rd_next[1:0] = irq_status_reg;
            {14'h0000, `SRTC_IDX_IRQ_MASK}: rd_next[1:0] = irq_mask_reg;
            default: hit_next = 1'b0;
        endcase
    end

    // ****************************************************************
    // Second tick and periodic interval decode
    // ****************************************************************
    always @*
    begin
        tick_pulse = (tick_cnt_reg == SECOND_CYCLES - 1);
        case (periodic_interval_select_reg)
            3'h1: period_last = 6'h00;
            3'h2: period_last = 6'h01;
            3'h3: period_last = 6'h03;
            3'h4: period_last = 6'h07;
            3'h5: period_last = 6'h0f;
            3'h6: period_last = 6'h1f;
            3'h7: period_last = 6'h3f;
            default: period_last = 6'h00;
        endcase
        periodic_pulse = tick_pulse && (periodic_interval_select_reg != 3'h0)
            && (period_cnt_reg >= period_last);
    end

    // ****************************************************************
    // Next seconds, status and mask
    // ****************************************************************
    // A time write at the edge that would have ticked wins, and that second
    // is lost: software should write just after a second has turned.
    always @*
    begin
        seconds_next = seconds_reg;
        if (wr_sec_hi)
            seconds_next[31:16] = merge16(seconds_reg[31:16], wb_dat_i, wb_sel_i);
        else if (wr_sec_lo)
            seconds_next[15:0] = merge16(seconds_reg[15:0], wb_dat_i, wb_sel_i);
        else if (tick_pulse)
            seconds_next = seconds_reg + 32'h0000_0001;
        alarm_pulse = alarm_enable_bit_reg && (seconds_next != seconds_reg)
            && (seconds_next == alarm_time_reg);
        status_next = irq_status_reg;
        if (wr_status && wb_sel_i[0])
            status_next = status_next & ~wb_dat_i[1:0];
        if (alarm_pulse)
            status_next[`SRTC_IRQ_ALARM_BIT] = 1'b1;
        if (periodic_pulse)
            status_next[`SRTC_IRQ_PERIODIC_BIT] = 1'b1;
        mask_next = irq_mask_reg;
        if (wr_mask && wb_sel_i[0])
            mask_next = wb_dat_i[1:0];
    end

    // ****************************************************************
    // Bus answer
    // ****************************************************************
    // Each taken request is answered at the next edge. The answer itself
    // blocks a second take, so ack or err stands for one cycle even when
    // the master keeps its strobe up one cycle longer.
    always @(posedge clk)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= req && hit_next;
            wb_err_o <= req && !hit_next;
        end
    end

    // Read data stands only beside ack and is zero at all other times.
    always @(posedge clk)
    begin
        if (rst)
            wb_dat_o <= 32'h0000_0000;
        else if (req && hit_next && !wb_we_i)
            wb_dat_o <= rd_next;
        else
            wb_dat_o <= 32'h0000_0000;
    end

    // ****************************************************************
    // Second tick
    // ****************************************************************
    // The tick counter runs free from reset. Time writes do not restart
    // it, so a written value advances at the next tick, which can come less than a second later.
    always @(posedge clk)
    begin
        if (rst)
            tick_cnt_reg <= 32'h0000_0000;
        else if (tick_pulse)
            tick_cnt_reg <= 32'h0000_0000;
        else
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end

    // ****************************************************************
    // Seconds counter
    // ****************************************************************
    always @(posedge clk)
    begin
        if (rst)
            seconds_reg <= `SRTC_RST_SECONDS;
        else
            seconds_reg <= seconds_next;
    end

    // ****************************************************************
    // Write tracker
    // ****************************************************************
    // The generator steps on every clock, so the value that a time write
    // picks up depends on when software happens to write.
    always @(posedge clk)
    begin
        if (rst)
            lfsr_reg <= `SRTC_RST_LFSR;
        else
            lfsr_reg <= lfsr_step(lfsr_reg);
    end

    always @(posedge clk)
    begin
        if (rst)
            time_write_tracker_reg <= `SRTC_RST_TRACKER;
        else if (wr_time)
            time_write_tracker_reg <= lfsr_reg;
    end

    // ****************************************************************
    // Valid and busy flags
    // ****************************************************************
    // Valid stays set until the next reset once either time half is written.
    always @(posedge clk)
    begin
        if (rst)
            valid_reg <= 1'b0;
        else if (wr_time)
            valid_reg <= 1'b1;
    end

    // Writes during busy are still taken; keeping out of them is up to software.
    always @(posedge clk)
    begin
        if (rst)
            busy_cnt_reg <= 3'h0;
        else if (wr_time)
            busy_cnt_reg <= `SRTC_SYNC_BUSY_CYCLES;
        else if (busy)
            busy_cnt_reg <= busy_cnt_reg - 3'h1;
    end

    // ****************************************************************
    // Alarm time
    // ****************************************************************
    // The halves are written one at a time. Software clears the alarm enable
    // while it rewrites the alarm time, as a half-written value can match.
    always @(posedge clk)
    begin
        if (rst)
            alarm_time_reg <= `SRTC_RST_ALARM;
        else if (wr_alm_hi)
            alarm_time_reg[31:16] <= merge16(alarm_time_reg[31:16], wb_dat_i, wb_sel_i);
        else if (wr_alm_lo)
            alarm_time_reg[15:0] <= merge16(alarm_time_reg[15:0], wb_dat_i, wb_sel_i);
    end

    // ****************************************************************
    // Control fields
    // ****************************************************************
    // The low byte holds the interval code and the high byte the alarm
    // enable; each follows its own byte select.
    always @(posedge clk)
    begin
        if (rst)
            alarm_enable_bit_reg <= 1'b0;
        else if (wr_ctrl && wb_sel_i[1])
            alarm_enable_bit_reg <= wb_dat_i[`SRTC_CTRL_ALM_EN_BIT];
    end

    always @(posedge clk)
    begin
        if (rst)
            periodic_interval_select_reg <= `SRTC_RST_PINT;
        else if (wr_ctrl && wb_sel_i[0])
            periodic_interval_select_reg <=
                wb_dat_i[`SRTC_CTRL_PINT_HI:`SRTC_CTRL_PINT_LO];
    end

    // ****************************************************************
    // Periodic interval counter
    // ****************************************************************
    // A new interval code restarts the count, so the first event after it
    // comes once the selected number of ticks has passed.
    always @(posedge clk)
    begin
        if (rst)
            period_cnt_reg <= 6'h00;
        else if (wr_ctrl && wb_sel_i[0])
            period_cnt_reg <= 6'h00;
        else if (periodic_pulse)
            period_cnt_reg <= 6'h00;
        else if (tick_pulse)
            period_cnt_reg <= period_cnt_reg + 6'h01;
    end

    // ****************************************************************
    // Interrupt status, mask and output
    // ****************************************************************
    // The output is formed from the next status and mask, so that it follows
    // a set, a clear or a mask write at the same edge as the registers.
    always @(posedge clk)
    begin
        if (rst)
        begin
            irq_status_reg <= `SRTC_RST_STATUS;
            irq_mask_reg <= `SRTC_RST_MASK;
            irq_o <= 1'b0;
        end
        else
        begin
            irq_status_reg <= status_next;
            irq_mask_reg <= mask_next;
            irq_o <= |(status_next & ~mask_next);
        end
    end

endmodule // srtc_seconds_clock

// [rtl/srtc_defs.vh]
// Register offsets, field positions, reset values and timing counts of the seconds clock.
`ifndef SRTC_DEFS_VH
`define SRTC_DEFS_VH

// ****************************************************************
// Register indexes (byte address is four times the index)
// ****************************************************************
`define SRTC_IDX_WR_TRACKER 16'h4020
`define SRTC_IDX_SEC_UPPER 16'h4021
`define SRTC_IDX_SEC_LOWER 16'h4022
`define SRTC_IDX_ALM_UPPER 16'h4023
`define SRTC_IDX_ALM_LOWER 16'h4024
`define SRTC_IDX_CTRL 16'h4025
`define SRTC_IDX_IRQ_STATUS 16'h4030
`define SRTC_IDX_IRQ_MASK 16'h4031

// ****************************************************************
// Control register fields
// ****************************************************************
`define SRTC_CTRL_VALID_BIT 15
`define SRTC_CTRL_BUSY_BIT 14
`define SRTC_CTRL_ALM_EN_BIT 10
`define SRTC_CTRL_PINT_HI 6
`define SRTC_CTRL_PINT_LO 4

// ****************************************************************
// Interrupt status and mask fields
// ****************************************************************
`define SRTC_IRQ_ALARM_BIT 0
`define SRTC_IRQ_PERIODIC_BIT 1

// ****************************************************************
// Reset values
// ****************************************************************
`define SRTC_RST_SECONDS 32'h0000_0000
`define SRTC_RST_ALARM 32'h0000_0000
`define SRTC_RST_PINT 3'h0
`define SRTC_RST_LFSR 16'hace1
`define SRTC_RST_MASK 2'h3
`define SRTC_RST_TRACKER 16'h0000
`define SRTC_RST_STATUS 2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define SRTC_CLK_HZ 100000000
`define SRTC_SECOND_NS 1000000000
`define SRTC_CLK_PERIOD_NS 10
`define SRTC_SECOND_CYCLES (`SRTC_SECOND_NS / `SRTC_CLK_PERIOD_NS)
`define SRTC_SYNC_BUSY_CYCLES 3'h4

`endif

// [verif/srtc_seconds_clock_chk.sv]
// Concurrent checks on the bus and interrupt ports of the seconds clock.
module srtc_chk (
    input wire clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire wb_err_o,
    input wire irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire [29:0] ix = wb_adr_i[31:2];
    wire hit = (ix >= 30'h4020 && ix <= 30'h4025) || ix == 30'h4030 || ix == 30'h4031;
    wire ans = wb_ack_o || wb_err_o;
    sequence s_req; wb_cyc_i && wb_stb_i && !ans; endsequence
    sequence s_pulse; ans ##1 !ans; endsequence
    property p_ack; s_req ##0 hit |=> wb_ack_o && !wb_err_o; endproperty
    a_ack: assert property (p_ack) else $error("mapped request not acked");
    property p_err; s_req ##0 !hit |=> wb_err_o && wb_dat_o == 32'h0; endproperty
    a_err: assert property (p_err) else $error("unmapped request not refused");
    property p_pulse; s_req |=> s_pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("answer not a single pulse");
    property p_cause; ans |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_cause: assert property (p_cause) else $error("answer without request");
    property p_hi; wb_ack_o |-> wb_dat_o[31:16] == 16'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits not zero");
    property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside ack");
    property p_excl; !(wb_ack_o && wb_err_o); endproperty
    a_excl: assert property (p_excl) else $error("ack and err together");
    property p_rst; $fell(rst) |-> !irq_o && !ans; endproperty
    a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule // srtc_chk
bind srtc_seconds_clock srtc_chk i_chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .irq_o(irq_o));

// [verif/srtc_seconds_clock_bench.sv]
// Self-checking bench for the seconds clock with alarm and periodic event.
module srtc_seconds_clock_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC = 20;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, err, irq;
    logic [31:0] adr = 0, wdat = 0, rdat, dat_o;
    logic [3:0] sel = 0;
    logic [32:0] q[$];
    logic [15:0] u, t0;
    time t;
    int n_fail = 0;
    int checks = 0;
    srtc_seconds_clock #(.SECOND_CYCLES(SC)) i_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err), .irq_o(irq));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_irq(input logic e);
        chk({32'h0, irq}, {32'h0, e});
    endtask
    task automatic chk_gap(input int c);
        chk(33'(($time - t) / 10), 33'(SC << (c - 1)));
    endtask
    task automatic bus(input logic wr, input logic [15:0] ix, input logic [15:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= {14'h0, ix, 2'h0};
        sel <= 4'h3;
        wdat <= {16'h0, d};
        do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] ix, input logic [32:0] e);
        q.push_back(e);
        bus(1'b0, ix, 16'h0);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // The monitor pairs each answered read issued through rd with the oldest queued expectation.
    always @(posedge clk)
        if ((ack === 1'b1 || err === 1'b1) && we === 1'b0 && q.size() > 0)
            chk({err, dat_o}, q.pop_front());
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish;
    end
    initial
    begin
        void'($urandom(32'h8cd2));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(16'h4025, 33'h0);
        rd(16'h4026, 33'h1_0000_0000);
        bus(1'b1, 16'h4031, 16'h0);
        for (int c = 1; c < 8; c++)
        begin
            bus(1'b1, 16'h4025, 16'(c << 4));
            bus(1'b1, 16'h4030, 16'h3);
            @(posedge irq);
            t = $time;
            bus(1'b1, 16'h4030, 16'h2);
            @(posedge irq);
            chk_gap(c);
        end
        // Writes land just after a tick, so the later reads see exactly three ticks.
        u = 16'($urandom);
        bus(1'b1, 16'h4022, 16'hfffe);
        bus(1'b1, 16'h4021, u);
        rd(16'h4025, 33'hc070);
        repeat (3 * SC) @(posedge clk);
        rd(16'h4022, 33'h1);
        rd(16'h4021, {17'h0, u + 16'h1});
        bus(1'b1, 16'h4025, 16'h0);
        bus(1'b1, 16'h4030, 16'h3);
        bus(1'b1, 16'h4023, 16'h0);
        bus(1'b1, 16'h4024, 16'h5);
        bus(1'b1, 16'h4021, 16'h0);
        bus(1'b1, 16'h4022, 16'h3);
        repeat (4 * SC) @(posedge clk);
        rd(16'h4030, 33'h0);
        bus(1'b1, 16'h4025, 16'h0400);
        bus(1'b1, 16'h4022, 16'h3);
        repeat (4 * SC) @(posedge clk);
        rd(16'h4030, 33'h1);
        chk_irq(1'b1);
        bus(1'b1, 16'h4031, 16'h1);
        repeat (2) @(posedge clk);
        chk_irq(1'b0);
        bus(1'b1, 16'h4030, 16'h1);
        rd(16'h4030, 33'h0);
        bus(1'b0, 16'h4020, 16'h0);
        t0 = rdat[15:0];
        bus(1'b1, 16'h4020, ~t0);
        rd(16'h4020, {17'h0, t0});
        bus(1'b1, 16'h4022, 16'h9);
        bus(1'b0, 16'h4020, 16'h0);
        chk({32'h0, rdat[15:0] != t0}, 33'h1);
        tally_and_finish;
    end
endmodule // srtc_seconds_clock_bench
